// File: design/nst_top.sv
// Module: time-sync request trigger, settings and last-success record
`timescale 1ns/10ps
// Function
// - Requests only on point-to-point IPv4/UDP links
// - Only direct synchronize and scheduler script trigger; autonomous mode unsupported
// - Server address held, up to 63 octets
// - Configurable destination port, standard 123
// - Auth 1 none only; keys ignored
// - Direct synchronize fires request immediately
// - One fixed script invokes synchronize
// - Script waits random delay, then fires
// - Random interval 0..65535 s, reset 0
// - Record and expose last success time
// - Last success cleared at reset, invalid
module nst_top
   import nst_pkg::*;
#(
   parameter int unsigned SEC_DIV = SEC_CYCLES
)
(
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // Link status, from modem logic in another domain
   input  wire logic        LINK_P2P,
   input  wire logic        LINK_IPV4_UDP,
   // Settings write port
   input  wire logic        CFG_WE,
   input  wire logic        CFG_ACTIVATED,
   input  wire logic [1:0]  CFG_AUTH,
   input  wire logic [15:0] CFG_PORT,
   input  wire logic [15:0] CFG_RAND_SEC,
   input  wire logic        ADDR_WE,
   input  wire logic [5:0]  ADDR_IDX,
   input  wire logic [7:0]  ADDR_DATA,
   input  wire logic [5:0]  ADDR_LEN,
   input  wire logic        ADDR_IS_NAME,
   // Triggers
   input  wire logic        SYNC_REQ,
   input  wire logic        SCRIPT_EXEC,
   input  wire logic [7:0]  SCRIPT_ID,
   input  wire logic [15:0] DEVICE_SEED,
   // Request completion and time
   input  wire logic        REQ_DONE,
   input  wire logic        REQ_OK,
   input  wire logic [31:0] RTC_TIME,
   // Settings readback
   output logic             ACTIVATED,
   output logic [1:0]       AUTH_METHOD,
   output logic [15:0]      SERVER_PORT,
   output logic [15:0]      RAND_SEC,
   output logic [5:0]       SERVER_LEN,
   output logic             SERVER_IS_NAME,
   input  wire logic [5:0]  RD_IDX,
   output logic [7:0]       RD_DATA,
   // Request to the network stack
   output logic             REQ_FIRE,
   output logic             REQ_PENDING,
   output logic [15:0]      REQ_PORT,
   // Status
   output logic             WAITING,
   output logic [31:0]      LAST_SYNC_TIME,
   output logic             LAST_SYNC_VALID
);
   nst_state_t  state;
   nst_state_t  next_state;
   logic [7:0]  addr_mem [0:62];
   logic [1:0]  p2p_sync;
   logic [1:0]  udp_sync;
   logic        link_ok;
   logic [15:0] delay_left;
   logic        sec_tick;
   logic        fire_now;
   logic        direct_go;
   logic        script_go;
   nst_rand_if  rq ();

   // Link status crosses domains through two flops
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         p2p_sync <= 2'b00;
         udp_sync <= 2'b00;
      end
      else
      begin
         p2p_sync <= {p2p_sync[0], LINK_P2P};
         udp_sync <= {udp_sync[0], LINK_IPV4_UDP};
      end
   end
   assign link_ok = p2p_sync[1] & udp_sync[1];

   // Settings; autonomous mode is stored but never acts
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         ACTIVATED   <= 1'b0;
         AUTH_METHOD <= AUTH_NONE;
         SERVER_PORT <= PORT_STD;
         RAND_SEC    <= RAND_RESET;
      end
      else if (CFG_WE)
      begin
         ACTIVATED   <= CFG_ACTIVATED;
         // Only no-security is held; other codes leave the method unchanged
         if (CFG_AUTH == AUTH_NONE)
            AUTH_METHOD <= CFG_AUTH;
         SERVER_PORT <= CFG_PORT;
         RAND_SEC    <= CFG_RAND_SEC;
      end
   end

   // Server address storage, one octet per write
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         SERVER_LEN     <= 6'h00;
         SERVER_IS_NAME <= 1'b0;
      end
      else if (ADDR_WE)
      begin
         SERVER_LEN     <= ADDR_LEN;
         SERVER_IS_NAME <= ADDR_IS_NAME;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (ADDR_WE && ADDR_IDX < 6'(ADDR_OCTETS))
         addr_mem[ADDR_IDX] <= ADDR_DATA;
   end

   // Readback of one octet; index 63 reads zero
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         RD_DATA <= 8'h00;
      else if (RD_IDX < 6'(ADDR_OCTETS))
         RD_DATA <= addr_mem[RD_IDX];
      else
         RD_DATA <= 8'h00;
   end

   // Trigger qualification; autonomous mode would bypass, so it blocks all
   assign direct_go = SYNC_REQ & ~ACTIVATED;
   assign script_go = SCRIPT_EXEC & (SCRIPT_ID == SCRIPT_SYNC) & ~ACTIVATED;

   // Random draw when the script runs
   assign rq.draw  = script_go && state == ST_IDLE && !direct_go;
   assign rq.limit = RAND_SEC;

   nst_rand nst_rand_inst
   (
      .clk  (CLOCK),
      .rst  (RST),
      .seed (DEVICE_SEED),
      .rq   (rq)
   );

   nst_sec #(.DIV(SEC_DIV)) nst_sec_inst
   (
      .clk     (CLOCK),
      .rst     (RST),
      .restart (rq.valid),
      .tick    (sec_tick)
   );

   // Fire once the delay is spent; a zero draw fires at once
   assign fire_now = (state == ST_WAIT) && rq.valid == 1'b0 &&
                     (delay_left == 16'h0000);

   // Sequencer
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
         begin
            if (direct_go)
               next_state = ST_ISSUE;
            else if (script_go)
               next_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (direct_go)
               next_state = ST_ISSUE;
            else if (fire_now)
               next_state = ST_ISSUE;
         end
         ST_ISSUE:
            next_state = link_ok ? ST_BUSY : ST_IDLE;
         ST_BUSY:
         begin
            if (REQ_DONE)
               next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Delay counter in whole seconds
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         delay_left <= 16'h0000;
      else if (rq.valid)
         delay_left <= rq.value;
      else if (state == ST_WAIT && sec_tick && delay_left != 16'h0000)
         delay_left <= delay_left - 16'h0001;
   end

   // Request strobe, suppressed when link is not point-to-point IPv4/UDP
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         REQ_FIRE    <= 1'b0;
         REQ_PENDING <= 1'b0;
         REQ_PORT    <= PORT_STD;
         WAITING     <= 1'b0;
      end
      else
      begin
         REQ_FIRE    <= (state == ST_ISSUE) && link_ok;
         REQ_PENDING <= (next_state == ST_BUSY);
         WAITING     <= (next_state == ST_WAIT);
         if (state == ST_ISSUE)
            REQ_PORT <= SERVER_PORT;
      end
   end

   // Last success timestamp, invalid from reset
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         LAST_SYNC_TIME  <= 32'h00000000;
         LAST_SYNC_VALID <= 1'b0;
      end
      else if (state == ST_BUSY && REQ_DONE && REQ_OK)
      begin
         LAST_SYNC_TIME  <= RTC_TIME;
         LAST_SYNC_VALID <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_FIRE_NEEDS_LINK: assert property (@(posedge CLOCK) disable iff (RST)
      REQ_FIRE |-> $past(link_ok))
      else $error("request fired without link");
   AST_DIRECT_FAST: assert property (@(posedge CLOCK) disable iff (RST)
      (state == ST_IDLE && direct_go && link_ok) ##1 link_ok |=> REQ_FIRE)
      else $error("direct sync not immediate");
   AST_NO_AUTONOMOUS: assert property (@(posedge CLOCK) disable iff (RST)
      (state == ST_IDLE && ACTIVATED) |=> state == ST_IDLE)
      else $error("trigger while activated");
   AST_SCRIPT_WAITS: assert property (@(posedge CLOCK) disable iff (RST)
      (state == ST_IDLE && script_go && !direct_go) |=> state == ST_WAIT)
      else $error("script did not wait");
   AST_AUTH_NONE: assert property (@(posedge CLOCK) disable iff (RST)
      AUTH_METHOD == AUTH_NONE)
      else $error("auth method not none");
   AST_DELAY_BOUND: assert property (@(posedge CLOCK) disable iff (RST)
      rq.valid |-> rq.value <= $past(RAND_SEC))
      else $error("delay above interval");
   AST_PORT_USED: assert property (@(posedge CLOCK) disable iff (RST)
      (state == ST_ISSUE) |=> REQ_PORT == $past(SERVER_PORT))
      else $error("wrong port");
   AST_LAST_TIME: assert property (@(posedge CLOCK) disable iff (RST)
      (state == ST_BUSY && REQ_DONE && REQ_OK) |=> LAST_SYNC_VALID &&
      LAST_SYNC_TIME == $past(RTC_TIME))
      else $error("last time not recorded");
   AST_WAIT_NO_FIRE: assert property (@(posedge CLOCK) disable iff (RST)
      (state == ST_WAIT && delay_left != 16'h0000 && !direct_go) |=> state != ST_ISSUE)
      else $error("fired before delay");
   AST_VALID_STAYS: assert property (@(posedge CLOCK) disable iff (RST)
      LAST_SYNC_VALID |=> LAST_SYNC_VALID)
      else $error("last success lost without reset");
   AST_FIRE_ONE_CYCLE: assert property (@(posedge CLOCK) disable iff (RST)
      REQ_FIRE |=> !REQ_FIRE)
      else $error("request strobe longer than one cycle");
   COV_CANCEL: cover property (@(posedge CLOCK) disable iff (RST)
      state == ST_WAIT && direct_go);
   COV_DIRECT: cover property (@(posedge CLOCK) disable iff (RST)
      direct_go ##2 REQ_FIRE);
   COV_SCRIPT: cover property (@(posedge CLOCK) disable iff (RST)
      (state == ST_WAIT) ##1 (state == ST_ISSUE));
   COV_SUCCESS: cover property (@(posedge CLOCK) disable iff (RST)
      LAST_SYNC_VALID);
   COV_SUPPRESS: cover property (@(posedge CLOCK) disable iff (RST)
      state == ST_ISSUE && !link_ok);
endmodule

// File: design/nst_pkg.sv
// Package: constants and types for the time-sync trigger block
package nst_pkg;
   // Clock rate and derived second tick
   localparam int unsigned CLK_HZ          = 250000000;
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned SEC_NS          = 1000000000;
   localparam int unsigned SEC_CYCLES      = SEC_NS / CLK_PERIOD_NS;
   // Setting widths and limits
   localparam int unsigned ADDR_OCTETS     = 63;
   localparam int unsigned ADDR_LEN_W      = 6;
   localparam int unsigned PORT_W          = 16;
   localparam int unsigned RAND_W          = 16;
   localparam int unsigned TIME_W          = 32;
   // Reset values and codes
   localparam logic [15:0] PORT_STD        = 16'h007b;
   localparam logic [15:0] RAND_RESET      = 16'h0000;
   localparam logic [1:0]  AUTH_NONE       = 2'h1;
   localparam logic [1:0]  AUTH_SHARED     = 2'h2;
   localparam logic [1:0]  AUTH_AUTOKEY    = 2'h3;
   localparam logic [7:0]  SCRIPT_SYNC     = 8'h01;
   localparam logic [15:0] LFSR_SEED_DFLT  = 16'h5a3c;
   // Sequencer states
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_ISSUE = 2'b10,
      ST_BUSY  = 2'b11
   } nst_state_t;
endpackage

// File: design/nst_rand_if.sv
// Interface: random delay request and answer between main and generator
`timescale 1ns/10ps
interface nst_rand_if;
   logic        draw;
   logic [15:0] limit;
   logic [15:0] value;
   logic        valid;
   modport gen  (input draw, input limit, output value, output valid);
   modport user (output draw, output limit, input value, input valid);
endinterface

// File: design/nst_rand.sv
// Module: pseudo-random whole-second delay generator
`timescale 1ns/10ps
module nst_rand
   import nst_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Per-device seed
   input  wire logic [15:0] seed,
   // Draw port
   nst_rand_if.gen          rq
);
   logic [15:0] lfsr;
   logic        seeded;
   logic [16:0] span;
   logic [31:0] prod;

   // Free-running LFSR, seeded after reset so devices differ
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lfsr   <= 16'h0001;
         seeded <= 1'b0;
      end
      else if (!seeded)
      begin
         lfsr   <= (seed == 16'h0000) ? LFSR_SEED_DFLT : seed;
         seeded <= 1'b1;
      end
      else
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   end

   // Scale into 0..limit by multiply, near uniform
   always_comb
   begin
      span = {1'b0, rq.limit} + 17'h00001;
      prod = 32'(lfsr) * 32'(span);
   end

   // Answer one cycle after the draw
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rq.value <= 16'h0000;
         rq.valid <= 1'b0;
      end
      else
      begin
         rq.valid <= rq.draw;
         if (rq.draw)
            rq.value <= prod[31:16];
      end
   end
endmodule

// File: design/nst_sec.sv
// Module: divider giving a one-cycle pulse per second
`timescale 1ns/10ps
module nst_sec
   import nst_pkg::*;
#(
   parameter int unsigned DIV = SEC_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic restart,
   output      logic tick
);
   logic [27:0] cnt;

   // Restart aligns the first second with the start of a wait
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt  <= 28'h0000000;
         tick <= 1'b0;
      end
      else if (restart)
      begin
         cnt  <= 28'h0000000;
         tick <= 1'b0;
      end
      else if (cnt == 28'(DIV - 1))
      begin
         cnt  <= 28'h0000000;
         tick <= 1'b1;
      end
      else
      begin
         cnt  <= cnt + 28'h0000001;
         tick <= 1'b0;
      end
   end
endmodule

// File: dv/nst_server_model.sv
// Behavioural remote time server answering block requests
`timescale 1ns/10ps
module nst_server_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Request and reply control
   input  wire logic       fire,
   input  wire logic       answer_ok,
   input  wire logic [7:0] lat,
   // Reply
   output logic            done,
   output logic            ok
);
   logic [7:0] cnt;
   logic       busy;
   logic       last;
   assign last = busy && cnt == 8'h00 && !fire;
   // Latency countdown, reply is a one-cycle pulse
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         cnt  <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         done <= last;
         if (fire)
         begin
            busy <= 1'b1;
            cnt  <= lat;
         end
         else if (last)
            busy <= 1'b0;
         else if (busy)
            cnt <= cnt - 8'h01;
      end
   end
   // Status toggles outside a reply, so a stale level is never trusted
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ok <= 1'b0;
      else
         ok <= last ? answer_ok : ~ok;
   end
endmodule

// File: dv/nst_top_tb.sv
// Self-checking bench for the time-sync trigger
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module nst_top_tb
   import nst_pkg::*;
;
   localparam int SEC_DIV = 10;
   logic        clock = 1'b0, rst = 1'b1, link_p2p = 1'b1, link_udp = 1'b1;
   logic        cfg_we = 1'b0, cfg_act = 1'b0, addr_we = 1'b0, addr_name = 1'b0;
   logic        sync_req = 1'b0, script_exec = 1'b0, answer_ok = 1'b1;
   logic [1:0]  cfg_auth = 2'h1, auth_q;
   logic [15:0] cfg_port = 16'h007b, cfg_rand = 16'h0000, port_q, rand_q, req_port;
   logic [15:0] seed = 16'h0000;
   logic [5:0]  addr_idx = 6'h00, addr_len = 6'h00, rd_idx = 6'h00, len_q;
   logic [7:0]  addr_data = 8'h00, script_id = 8'h00, lat = 8'h00, rd_data;
   logic [31:0] rtc = 32'h00000000, last_time;
   logic        act_q, name_q, req_fire, req_pend, waiting, last_valid, req_done, req_ok;
   int          failures = 0, n_tests = 0, n;
   // Clock at 250 MHz
   always #2 clock = ~clock;
   nst_top #(.SEC_DIV(SEC_DIV)) nst_top_inst (.CLOCK(clock), .RST(rst), .LINK_P2P(link_p2p),
      .LINK_IPV4_UDP(link_udp), .CFG_WE(cfg_we), .CFG_ACTIVATED(cfg_act), .CFG_AUTH(cfg_auth),
      .CFG_PORT(cfg_port), .CFG_RAND_SEC(cfg_rand), .ADDR_WE(addr_we), .ADDR_IDX(addr_idx),
      .ADDR_DATA(addr_data), .ADDR_LEN(addr_len), .ADDR_IS_NAME(addr_name),
      .SYNC_REQ(sync_req), .SCRIPT_EXEC(script_exec), .SCRIPT_ID(script_id),
      .DEVICE_SEED(seed), .REQ_DONE(req_done), .REQ_OK(req_ok), .RTC_TIME(rtc),
      .ACTIVATED(act_q), .AUTH_METHOD(auth_q), .SERVER_PORT(port_q), .RAND_SEC(rand_q),
      .SERVER_LEN(len_q), .SERVER_IS_NAME(name_q), .RD_IDX(rd_idx), .RD_DATA(rd_data),
      .REQ_FIRE(req_fire), .REQ_PENDING(req_pend), .REQ_PORT(req_port), .WAITING(waiting),
      .LAST_SYNC_TIME(last_time), .LAST_SYNC_VALID(last_valid));
   nst_server_model nst_server_model_inst (.clk(clock), .rst(rst), .fire(req_fire),
      .answer_ok(answer_ok), .lat(lat), .done(req_done), .ok(req_ok));
   // Inputs change 1 ns after the edge
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic cfg(input logic a, input logic [1:0] au, input logic [15:0] p, r);
      {cfg_act, cfg_auth, cfg_port, cfg_rand, cfg_we} = {a, au, p, r, 1'b1};
      step(1);
      cfg_we = 1'b0;
      step(1);
   endtask
   // Pulse a trigger, return cycles until the request fires, -1 if never
   task automatic trig(input logic scr, input logic [7:0] id, input int max, output int c);
      c = -1;
      script_id = id;
      script_exec = scr;
      sync_req = ~scr;
      for (int i = 1; i <= max && c < 0; i++)
      begin
         step(1);
         // Cleared once only, so a following call never re-drives it in one step
         if (i == 1)
            {sync_req, script_exec} = 2'b00;
         if (req_fire === 1'b1)
            c = i;
      end
   endtask
   // Bounded wait for the server reply to land
   task automatic reply();
      for (int k = 0; k < 300 && req_pend !== 1'b0; k++)
         step(1);
      step(1);
   endtask
   // Script fire cycle: 4 with no delay, else 5 plus whole seconds up to lim
   function automatic bit sec_ok(input int c, input int lim);
      return c == 4 || (c > 4 && (c - 5) % SEC_DIV == 0 && c <= 5 + lim * SEC_DIV);
   endfunction
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #100000;
      failures++;
      finish_test();
   end
   // Values after reset
   task automatic test_reset();
      `CHK({port_q, req_port, auth_q}, {PORT_STD, PORT_STD, AUTH_NONE})
      `CHK({rand_q, last_valid}, 17'h00000)
   endtask
   // Settings load; unsupported auth codes leave no security in place
   task automatic test_settings();
      cfg(1'b0, AUTH_SHARED, 16'h1234, 16'hffff);
      `CHK({port_q, rand_q}, 32'h1234ffff)
      `CHK(auth_q, AUTH_NONE)
      cfg(1'b0, AUTH_AUTOKEY, 16'h1234, 16'h0000);
      `CHK(auth_q, AUTH_NONE)
   endtask
   // Octet 63 lies beyond the address store and must be dropped
   task automatic test_address();
      for (int i = 0; i < 64; i++)
      begin
         {addr_we, addr_idx, addr_data, addr_len, addr_name} = {1'b1, 6'(i), 8'(i) ^ 8'ha5,
            6'h3f, 1'b1};
         step(1);
      end
      addr_we = 1'b0;
      for (int i = 0; i < 64; i++)
      begin
         rd_idx = 6'(i);
         step(1);
         `CHK(rd_data, (i == 63) ? 8'h00 : 8'(i) ^ 8'ha5)
      end
      `CHK({len_q, name_q}, 7'h7f)
   endtask
   // Direct synchronize fires at once; only a good reply is recorded
   task automatic test_direct();
      rtc = 32'h11223344;
      trig(1'b0, 8'h00, 10, n);
      `CHK(n, 2)
      `CHK({req_port, waiting}, 17'h02468)
      reply();
      `CHK({last_time, last_valid}, 33'h022446689)
      {rtc, answer_ok, lat} = {32'h55667788, 1'b0, 8'h14};
      trig(1'b0, 8'h00, 10, n);
      `CHK(n, 2)
      reply();
      `CHK({last_time, last_valid}, 33'h022446689)
      answer_ok = 1'b1;
   endtask
   // Script id, zero interval, whole-second delays, cancel by a direct request
   task automatic test_script();
      trig(1'b1, 8'h02, 30, n);
      `CHK(n, -1)
      trig(1'b1, SCRIPT_SYNC, 8, n);
      `CHK(n, 4)
      reply();
      cfg(1'b0, AUTH_NONE, 16'h1234, 16'h0003);
      // Script run twice as a periodic scheduler would
      repeat (2)
      begin
         trig(1'b1, SCRIPT_SYNC, 4 * SEC_DIV + 8, n);
         `CHK(sec_ok(n, 3), 1'b1)
         reply();
      end
      cfg(1'b0, AUTH_NONE, 16'h1234, 16'hffff);
      trig(1'b1, SCRIPT_SYNC, 3, n);
      `CHK({waiting, n}, {1'b1, -32'sd1})
      trig(1'b0, 8'h00, 10, n);
      `CHK(n, 2)
      reply();
   endtask
   // Activated mode is not supported, so no trigger may fire
   task automatic test_activated();
      cfg(1'b1, AUTH_NONE, 16'h1234, 16'h0000);
      `CHK(act_q, 1'b1)
      trig(1'b0, 8'h00, 20, n);
      `CHK(n, -1)
      trig(1'b1, SCRIPT_SYNC, 20, n);
      `CHK(n, -1)
      cfg(1'b0, AUTH_NONE, 16'h1234, 16'h0000);
   endtask
   // Either link condition missing suppresses the request; both back restores it
   task automatic test_link();
      for (int i = 0; i < 2; i++)
      begin
         {link_p2p, link_udp} = i ? 2'b10 : 2'b01;
         step(4);
         trig(1'b0, 8'h00, 20, n);
         `CHK({n, req_pend}, {-32'sd1, 1'b0})
      end
      {link_p2p, link_udp} = 2'b11;
      step(4);
      trig(1'b0, 8'h00, 10, n);
      `CHK(n, 2)
      reply();
   endtask
   // Reset in mid-run clears the record; a non-zero seed still bounds the delay
   task automatic test_midreset();
      {seed, rst} = {16'h0c35, 1'b1};
      step(2);
      rst = 1'b0;
      step(4);
      `CHK({last_time, last_valid, rand_q}, 49'h0)
      cfg(1'b0, AUTH_NONE, 16'h1234, 16'h0002);
      trig(1'b1, SCRIPT_SYNC, 3 * SEC_DIV + 8, n);
      `CHK(sec_ok(n, 2), 1'b1)
      reply();
   endtask
   // Main sequence
   initial
   begin
      step(12);
      rst = 1'b0;
      step(4);
      test_reset();
      test_settings();
      test_address();
      test_direct();
      test_script();
      test_activated();
      test_link();
      test_midreset();
      finish_test();
   end
endmodule
